// >>> design/cvm_consts.svh
`ifndef CVM_CONSTS_SVH
`define CVM_CONSTS_SVH

// Register byte offsets
`define CVM_ADDR_CTRL 8'h00
`define CVM_ADDR_PTR 8'h04
`define CVM_ADDR_DATA 8'h08
`define CVM_ADDR_STAT 8'h0c

// Control register layout and reset value
`define CVM_CTRL_W 13
`define CVM_CTRL_RESET 13'h0002
`define CVM_CTRL_HPE_BIT 0

// Pointer register layout
`define CVM_PTR_AUTOSTEP_BIT 7
`define CVM_PTR_W 5
`define CVM_PTR_FIRST 5'h01
`define CVM_PTR_BLK1_END 5'h08
`define CVM_PTR_BLK2_END 5'h11

// Highest master-clock ratio code (1024x / 512x / 256x)
`define CVM_MCLK_TOP 3'h4

// Oversampling ratios
`define CVM_OSR_SINGLE 8'h80
`define CVM_OSR_DOUBLE 8'h40
`define CVM_OSR_QUAD 8'h20

// Power-up sequence lengths in frame-clock cycles
`define CVM_SEQ_SINGLE 12'h200
`define CVM_SEQ_DOUBLE 12'h400
`define CVM_SEQ_QUAD 12'h800

// Timing
`define CVM_CLK_MHZ 40
`define CVM_HOLD_NS 250000
`define CVM_TICK_NS 22675

`endif

// >>> design/cvm_pkg.sv
package cvm_pkg;

  typedef enum logic [2:0] {
    st_quiet = 3'b000,
    st_sa_seq = 3'b001,
    st_sa_run = 3'b010,
    st_cp_down = 3'b011,
    st_cp_seq = 3'b100,
    st_cp_run = 3'b101
  } cvm_state_type;

  typedef enum logic [1:0] {
    spd_single = 2'b00,
    spd_double = 2'b01,
    spd_quad = 2'b10,
    spd_bitstream = 2'b11
  } cvm_speed_type;

  typedef struct packed {
    logic [2:0] mclk_code;
    logic emphasis_curve_select;
    logic rolloff_choice;
    logic master_clock_halving;
    logic [2:0] serial_format_field;
    cvm_speed_type speed_mode_field;
    logic power_down_bit;
    logic host_port_enable;
  } cvm_ctrl_type;

  typedef struct packed {
    logic [2:0] serial_format;
    cvm_speed_type speed;
    logic one_bit;
    logic rate_128;
    logic [3:0] data_ratio;
    logic [7:0] oversample;
    logic slow_filter;
    logic deemph;
    logic host_mode;
    logic powered;
    logic ratio_ok;
  } cvm_mode_type;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } cvm_ahb_req_type;

endpackage

// >>> design/cvm_sync3.sv
`timescale 1ns/100ps
module cvm_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic [2:0] stage_r;
      logic out_r;
      // Output follows only once the second and third stages agree
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          stage_r <= 3'h0;
          out_r <= 1'b0;
        end else begin
          stage_r <= {stage_r[1:0], async_in[i]};
          if (stage_r[1] == stage_r[2]) begin
            out_r <= stage_r[2];
          end
        end
      end
      assign sync_out[i] = out_r;
    end
  endgenerate

endmodule

// >>> design/cvm_mode_top.sv
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "cvm_consts.svh"

// How it works
// [RQ1] Stand-alone: straps one/zero pick LJ, I2S, RJ16 or RJ24 audio format.
// [RQ2] Stand-alone: straps three/two pick single, single with de-emphasis, double, quad.
// [RQ3] Stand-alone one-bit: strap two picks 64x/128x, straps one/zero the clock ratio.
// [RQ4] Stand-alone: a frame clock held high enters one-bit stream operation.
// [RQ5] Host mode: speed field selects one-bit; format field sets rate and ratio.
// [RQ6] Oversampling is 128x single, 64x double, 32x quad.
// [RQ7] Speed comes from straps stand-alone, from the speed field in host mode.
// [RQ8] Top clock ratio accepted only in host mode with clock halving set.
// [RQ9] While device reset is low, settings stay default and converter stays quiet.
// [RQ10] After reset, stand-alone power-up runs 512/1024/2048 frames; port stays usable.
// [RQ11] Setting host enable during that sequence stops it and loads default settings.
// [RQ12] Host mode: powered down while power-down bit is 1; cleared starts power-up.
// [RQ13] Host sets enable before sequence ends, loads settings, then clears power-down.
// [RQ14] Fast or slow roll-off by rolloff choice; stand-alone always fast.
// [RQ15] Pointer bit seven enables auto-step; when 0 the pointer stays fixed.
// [RQ16] Auto-step advances within 01h-08h and 09h-11h, never from 08h to 09h.
// [RQ17] Control access works with timing unrelated to the audio frame clock.
// [RQ18] Host keeps control pins static when idle.
// [RQ19] Source ties unused audio pins low or keeps them clocked in one-bit mode.
// [RQ20] Host enables control-port mode by a write; until then pins are straps.
module cvm_mode_top #(
  parameter int HOLD_CYCLES = (`CVM_HOLD_NS * `CVM_CLK_MHZ + 999) / 1000,
  parameter int TICK_CYCLES = (`CVM_TICK_NS * `CVM_CLK_MHZ) / 1000
) (
  input wire logic clk,
  input wire logic sys_rst,
  input cvm_pkg::cvm_ahb_req_type ahb_req,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic converter_rst_n,
  input wire logic frame_clock,
  input wire logic strap_pin_zero,
  input wire logic strap_pin_one,
  input wire logic strap_pin_two,
  input wire logic strap_pin_three,
  output cvm_pkg::cvm_mode_type mode_out,
  output logic sequence_busy
);
  import cvm_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int DEPTH = 1 << `CVM_PTR_W;

  function automatic logic addr_is(input logic [31:0] a, input logic [7:0] off);
    addr_is = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  function automatic logic [3:0] ratio_of(input logic rate_128, input logic [1:0] sel);
    case ({rate_128, sel})
      3'b000: ratio_of = 4'h4;
      3'b001: ratio_of = 4'h6;
      3'b010: ratio_of = 4'h8;
      3'b011: ratio_of = 4'hc;
      3'b100: ratio_of = 4'h2;
      3'b101: ratio_of = 4'h3;
      3'b110: ratio_of = 4'h4;
      3'b111: ratio_of = 4'h6;
      default: ratio_of = 4'h0;
    endcase
  endfunction

  // Input synchronisers
  logic [5:0] sync_q;
  cvm_sync3 #(.WIDTH(6)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({converter_rst_n, frame_clock, strap_pin_three, strap_pin_two,
               strap_pin_one, strap_pin_zero}),
    .sync_out(sync_q)
  ); // [RQ17]

  wire rst_n_s = sync_q[5];
  wire frame_s = sync_q[4];
  wire [3:0] strap_s = sync_q[3:0];
  wire dev_clr = sys_rst | ~rst_n_s; // [RQ9]

  // Registers
  cvm_ctrl_type ctrl_r;
  cvm_ctrl_type ctrl_nxt;
  cvm_state_type state_r;
  cvm_state_type state_nxt;
  cvm_mode_type mode_r;
  cvm_mode_type mode_nxt;
  logic [7:0] mem [0:DEPTH-1];
  logic [`CVM_PTR_W-1:0] ptr_r;
  logic autostep_r;
  logic wr_pend_r;
  logic [31:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic frame_d_r;
  logic [HW-1:0] hold_cnt_r;
  logic hold_r;
  logic [TW-1:0] tick_cnt_r;
  logic [11:0] seq_cnt_r;
  logic busy_r;

  // Bus decode
  wire take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
  wire rd_take = take & ~ahb_req.hwrite;
  wire wr_ctrl = wr_pend_r & addr_is(wr_addr_r, `CVM_ADDR_CTRL);
  wire wr_ptr = wr_pend_r & addr_is(wr_addr_r, `CVM_ADDR_PTR);
  wire wr_data = wr_pend_r & addr_is(wr_addr_r, `CVM_ADDR_DATA);
  wire rd_data = rd_take & addr_is(ahb_req.haddr, `CVM_ADDR_DATA);
  wire [31:0] wdata = ahb_req.hwdata;
  wire cvm_ctrl_type ctrl_wr = cvm_ctrl_type'(wdata[`CVM_CTRL_W-1:0]);

  // Pointer stepping
  wire in_block = (ptr_r >= `CVM_PTR_FIRST) && (ptr_r != `CVM_PTR_BLK1_END) &&
                  (ptr_r < `CVM_PTR_BLK2_END); // [RQ16]
  wire step = (wr_data | rd_data) & autostep_r & in_block; // [RQ15]

  // Host enable first set: defaults with enable kept
  wire hpe_rise = wr_ctrl & ctrl_wr.host_port_enable & ~ctrl_r.host_port_enable; // [RQ20]
  cvm_ctrl_type ctrl_dflt;
  always_comb begin
    ctrl_dflt = cvm_ctrl_type'(`CVM_CTRL_RESET);
    ctrl_dflt.host_port_enable = 1'b1;
  end
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (hpe_rise) begin
      ctrl_nxt = ctrl_dflt; // [RQ11]
    end else if (wr_ctrl) begin
      ctrl_nxt = ctrl_wr;
      ctrl_nxt.host_port_enable = ctrl_r.host_port_enable;
    end
  end

  // Frame clock timing
  wire frame_rise = frame_s & ~frame_d_r;
  wire hold_full = hold_cnt_r == HW'(HOLD_CYCLES);
  wire tick = tick_cnt_r == TW'(TICK_CYCLES - 1);

  // Effective mode
  wire cp = ctrl_r.host_port_enable;
  wire cvm_speed_type sa_speed = !strap_s[3] ? spd_single :
                                 (strap_s[2] ? spd_quad : spd_double); // [RQ2]
  wire cvm_speed_type sa_eff = hold_r ? spd_bitstream : sa_speed; // [RQ4]
  wire cvm_speed_type speed_eff = cp ? ctrl_r.speed_mode_field : sa_eff; // [RQ7]
  wire one_bit = speed_eff == spd_bitstream; // [RQ5]
  wire rate_128 = cp ? ctrl_r.serial_format_field[2] : strap_s[2]; // [RQ3]
  wire [1:0] ratio_sel = cp ? ctrl_r.serial_format_field[1:0] : strap_s[1:0]; // [RQ3]
  wire [2:0] fmt = cp ? ctrl_r.serial_format_field : {1'b0, strap_s[1:0]}; // [RQ1]
  wire [7:0] osr = (speed_eff == spd_single) ? `CVM_OSR_SINGLE :
                   (speed_eff == spd_double) ? `CVM_OSR_DOUBLE :
                   (speed_eff == spd_quad) ? `CVM_OSR_QUAD : 8'h00; // [RQ6]
  wire top_ratio = ctrl_r.mclk_code == `CVM_MCLK_TOP;
  wire ratio_ok = (ctrl_r.mclk_code < `CVM_MCLK_TOP) |
                  (top_ratio & cp & ctrl_r.master_clock_halving); // [RQ8]
  wire [11:0] seq_len = (speed_eff == spd_double) ? `CVM_SEQ_DOUBLE :
                        (speed_eff == spd_quad) ? `CVM_SEQ_QUAD : `CVM_SEQ_SINGLE; // [RQ10]
  wire seq_tick = one_bit ? tick : frame_rise;
  wire seq_done = seq_tick && (seq_cnt_r == seq_len - 12'h001);
  wire in_seq = (state_r == st_sa_seq) || (state_r == st_cp_seq);
  wire powered = (state_r == st_sa_run) || (state_r == st_cp_run);

  always_comb begin
    mode_nxt.serial_format = fmt;
    mode_nxt.speed = speed_eff;
    mode_nxt.one_bit = one_bit;
    mode_nxt.rate_128 = one_bit & rate_128;
    mode_nxt.data_ratio = one_bit ? ratio_of(rate_128, ratio_sel) : 4'h0;
    mode_nxt.oversample = osr;
    mode_nxt.slow_filter = cp & ctrl_r.rolloff_choice; // [RQ14]
    mode_nxt.deemph = cp ? ctrl_r.emphasis_curve_select :
                      (~strap_s[3] & strap_s[2] & ~hold_r); // [RQ2]
    mode_nxt.host_mode = cp;
    mode_nxt.powered = powered;
    mode_nxt.ratio_ok = ratio_ok;
  end

  // Power sequencing
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_quiet: begin
        state_nxt = st_sa_seq; // [RQ10]
      end
      st_sa_seq: begin
        if (cp) begin
          state_nxt = st_cp_down; // [RQ11]
        end else if (seq_done) begin
          state_nxt = st_sa_run;
        end
      end
      st_sa_run: begin
        if (cp) begin
          state_nxt = st_cp_down; // [RQ13]
        end
      end
      st_cp_down: begin
        if (!ctrl_r.power_down_bit) begin
          state_nxt = st_cp_seq; // [RQ12]
        end
      end
      st_cp_seq: begin
        if (ctrl_r.power_down_bit) begin
          state_nxt = st_cp_down; // [RQ12]
        end else if (seq_done) begin
          state_nxt = st_cp_run;
        end
      end
      st_cp_run: begin
        if (ctrl_r.power_down_bit) begin
          state_nxt = st_cp_down; // [RQ12]
        end
      end
      default: begin
        state_nxt = st_quiet;
      end
    endcase
  end

  // Read mux
  wire [31:0] rd_mux =
    addr_is(ahb_req.haddr, `CVM_ADDR_CTRL) ? {19'h00000, ctrl_r} :
    addr_is(ahb_req.haddr, `CVM_ADDR_PTR) ? {24'h000000, autostep_r, 2'b00, ptr_r} :
    addr_is(ahb_req.haddr, `CVM_ADDR_DATA) ? {24'h000000, mem[ptr_r]} :
    addr_is(ahb_req.haddr, `CVM_ADDR_STAT) ? {5'h00, state_r, mode_r} : 32'h00000000;

  // Bus slave
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 32'h00000000;
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      wr_pend_r <= take & ahb_req.hwrite;
      if (take) begin
        wr_addr_r <= ahb_req.haddr;
      end
      if (rd_take) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Settings, pointer and byte store
  always_ff @(posedge clk) begin
    if (dev_clr) begin
      ctrl_r <= cvm_ctrl_type'(`CVM_CTRL_RESET); // [RQ9]
      ptr_r <= '0;
      autostep_r <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_ptr) begin
        autostep_r <= wdata[`CVM_PTR_AUTOSTEP_BIT];
        ptr_r <= wdata[`CVM_PTR_W-1:0];
      end else if (step) begin
        ptr_r <= ptr_r + `CVM_PTR_W'(1); // [RQ16]
      end
      if (wr_data) begin
        mem[ptr_r] <= wdata[7:0];
      end
    end
  end

  // Frame clock hold detector and fallback tick
  always_ff @(posedge clk) begin
    if (dev_clr) begin
      frame_d_r <= 1'b0;
      hold_cnt_r <= '0;
      hold_r <= 1'b0;
      tick_cnt_r <= '0;
    end else begin
      frame_d_r <= frame_s;
      if (!frame_s) begin
        hold_cnt_r <= '0;
      end else if (!hold_full) begin
        hold_cnt_r <= hold_cnt_r + HW'(1);
      end
      hold_r <= frame_s & hold_full; // [RQ4]
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TW'(1);
    end
  end

  // State, sequence counter and outputs
  always_ff @(posedge clk) begin
    if (dev_clr) begin
      state_r <= st_quiet;
      seq_cnt_r <= 12'h000;
      mode_r <= '0; // [RQ9]
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r || !in_seq) begin
        seq_cnt_r <= 12'h000;
      end else if (seq_tick) begin
        seq_cnt_r <= seq_cnt_r + 12'h001; // [RQ10]
      end
      mode_r <= mode_nxt;
      busy_r <= (state_nxt == st_sa_seq) || (state_nxt == st_cp_seq);
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign mode_out = mode_r;
  assign sequence_busy = busy_r;

endmodule

// >>> dv/cvm_src_model.sv
`timescale 1ns/100ps
module cvm_src_model (
  input wire logic hold_high,
  output logic frame_clock
);
  logic tick;
  // Free-running frame clock, phase unrelated to clk
  initial begin
    tick = 1'b0;
    #7.3;
    forever #100 tick = ~tick;
  end
  // Held high selects one-bit input; no other audio pins are modelled
  assign frame_clock = hold_high ? 1'b1 : tick;
endmodule

// >>> dv/cvm_mode_top_assertions.sv
`timescale 1ns/100ps
module cvm_mode_chk #(
  parameter int HOLD_CYCLES = 20,
  parameter int TICK_CYCLES = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input cvm_pkg::cvm_ahb_req_type ahb_req,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic converter_rst_n,
  input wire logic frame_clock,
  input wire logic strap_pin_zero,
  input wire logic strap_pin_one,
  input wire logic strap_pin_two,
  input wire logic strap_pin_three,
  input cvm_pkg::cvm_mode_type mode_out,
  input wire logic sequence_busy
);
  import cvm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RST_QUIET: assert property (
    !converter_rst_n [*6] |=> mode_out == '0 && !sequence_busy)
    else $error("settings not quiet in device reset");
  AST_SEQ_START: assert property (
    $rose(converter_rst_n) |-> ##[2:10] sequence_busy)
    else $error("power-up sequence did not start");
  AST_BUSY_DOWN: assert property (
    sequence_busy |-> !mode_out.powered)
    else $error("powered while sequence counts");
  AST_OSR: assert property (
    mode_out.powered && !mode_out.one_bit |-> mode_out.oversample ==
    (mode_out.speed == spd_single ? 8'h80 : mode_out.speed == spd_double ? 8'h40 : 8'h20))
    else $error("oversample does not match speed");
  AST_ONEBIT: assert property (
    mode_out.one_bit |-> mode_out.speed == spd_bitstream && mode_out.oversample == 8'h00)
    else $error("one-bit mode fields wrong");
  AST_RATIO: assert property (
    mode_out.one_bit |-> (mode_out.rate_128 ? mode_out.data_ratio inside {2, 3, 4, 6}
    : mode_out.data_ratio inside {4, 6, 8, 12}))
    else $error("one-bit clock ratio wrong");
  AST_SA_FAST: assert property (
    !mode_out.host_mode |-> !mode_out.slow_filter)
    else $error("slow filter in stand-alone");
  AST_SA_FMT: assert property (
    !mode_out.host_mode && !mode_out.one_bit |-> !mode_out.serial_format[2])
    else $error("stand-alone format out of range");
  AST_DEEMPH: assert property (
    mode_out.deemph && !mode_out.host_mode |-> mode_out.speed == spd_single)
    else $error("de-emphasis outside single speed");
endmodule

bind cvm_mode_top cvm_mode_chk #(.HOLD_CYCLES(HOLD_CYCLES), .TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk, .sys_rst, .ahb_req, .hrdata, .hreadyout, .hresp, .converter_rst_n, .frame_clock,
  .strap_pin_zero, .strap_pin_one, .strap_pin_two, .strap_pin_three, .mode_out,
  .sequence_busy);

// >>> dv/cvm_mode_top_tb_top.sv
`timescale 1ns/100ps
module cvm_mode_top_tb_top;
  import cvm_pkg::*;
  logic clk, sys_rst, crst_n, hold, hsel, hwrite, hreadyout, hresp, busy, fclk;
  logic [3:0] s;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  cvm_ahb_req_type req;
  cvm_mode_type m;
  int err_count, cmp_count, n;
  logic [7:0] pst [3] = '{8'h87, 8'h10, 8'h90};
  logic [7:0] pex [3] = '{8'h88, 8'h10, 8'h91};
  assign req = '{hsel, haddr, htrans, hwrite, hsize, hwdata, hreadyout};
  cvm_src_model u_src (.hold_high(hold), .frame_clock(fclk));
  cvm_mode_top #(.HOLD_CYCLES(20), .TICK_CYCLES(4)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .ahb_req(req), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .converter_rst_n(crst_n), .frame_clock(fclk), .strap_pin_zero(s[0]),
    .strap_pin_one(s[1]), .strap_pin_two(s[2]), .strap_pin_three(s[3]), .mode_out(m),
    .sequence_busy(busy));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic wait_busy(input logic lvl);
    n = 0;
    while (busy !== lvl && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [1:0] sa_spd(input logic [1:0] x);
    return x[1] ? {x[0], ~x[0]} : 2'b00;
  endfunction
  function automatic logic [3:0] ratio(input logic [2:0] x);
    logic [3:0] b;
    b = (x[1:0] == 2'b11) ? 4'h6 : {2'b00, x[1:0]} + 4'h2;
    return x[2] ? b : b << 1;
  endfunction
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    complete_run;
  end
  initial begin
    {sys_rst, crst_n, hold, hsel, hwrite, s} = 9'h100;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'b00, 3'b010};
    {err_count, cmp_count} = 0;
    void'($urandom(32'h1935));
    cyc(6);
    sys_rst <= 1'b0;
    bus(1'b1, 32'h0, 32'h1);
    bus(1'b0, 32'h0, 32'h0);
    chk(q, 32'h2);
    cyc(8);
    chk(32'(m), 32'h0);
    crst_n <= 1'b1;
    wait_busy(1'b1);
    chk(32'(n < 12), 32'h1);
    wait_busy(1'b0);
    chk(32'(n > 4000 && n < 4200), 32'h1);
    for (int i = 0; i < 24; i++) begin
      s <= (i < 16) ? 4'(i) : 4'($urandom);
      cyc(12);
      chk(32'(m.serial_format), {30'h0, s[1:0]});
      chk(32'(m.speed), 32'(sa_spd(s[3:2])));
      chk(32'(m.deemph), 32'(s[3:2] == 2'b01));
      chk(32'(m.oversample), 32'(sa_spd(s[3:2]) == 0 ? 8'h80 : s[2] ? 8'h20 : 8'h40));
      chk(32'(m.slow_filter), 32'h0);
    end
    hold <= 1'b1;
    cyc(40);
    for (int i = 0; i < 8; i++) begin
      s <= 4'(i);
      cyc(12);
      chk(32'(m.one_bit), 32'h1);
      chk(32'(m.rate_128), 32'(i / 4));
      chk(32'(m.data_ratio), 32'(ratio(3'(i))));
    end
    hold <= 1'b0;
    cyc(12);
    chk(32'(m.one_bit), 32'h0);
    crst_n <= 1'b0;
    cyc(8);
    crst_n <= 1'b1;
    wait_busy(1'b1);
    bus(1'b1, 32'h0, 32'h1ffd);
    bus(1'b0, 32'h0, 32'h0);
    chk(q, 32'h3);
    chk(32'(busy), 32'h0);
    bus(1'b1, 32'h0, 32'h1187);
    s <= 4'($urandom);
    cyc(4);
    chk(32'({m.host_mode, m.powered}), 32'h2);
    bus(1'b1, 32'h0, 32'h1185);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk(32'(n > 8100 && n < 8300), 32'h1);
    cyc(2);
    chk(32'({m.speed, m.oversample}), 32'h140);
    chk(32'({m.slow_filter, m.ratio_ok, m.powered}), 32'h7);
    bus(1'b1, 32'h0, 32'h1105);
    cyc(4);
    chk(32'(m.ratio_ok), 32'h0);
    bus(1'b1, 32'h0, 32'h7d);
    cyc(4);
    chk(32'({m.one_bit, m.rate_128, m.data_ratio}), 32'h36);
    bus(1'b1, 32'h0, 32'h7f);
    cyc(4);
    chk(32'(m.powered), 32'h0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 32'h4, {24'h0, pst[i]});
      repeat (2) bus(1'b1, 32'h8, $urandom);
      bus(1'b0, 32'h4, 32'h0);
      chk(q, {24'h0, pex[i]});
    end
    bus(1'b0, 32'hc, 32'h0);
    chk(32'(q[26:24]), 32'h3);
    chk(32'({hresp, hreadyout}), 32'h1);
    bus(1'b0, 32'h40, 32'h0);
    chk(q, 32'h0);
    complete_run;
  end
endmodule
